// File: rtl/irqf_pkg.sv
// Purpose: Constants and types of the flag block.
// Assumes: Byte address is four times the index.
// Notes:   Every constant is named once here.
package irqf_pkg;

    // ****************************************************************
    // Register indexes.
    // ****************************************************************
    localparam logic [3:0] IDX_COM_EN  = 4'h2; // Common enable register.
    localparam logic [3:0] IDX_AUX_EN  = 4'h3; // Auxiliary enable register.
    localparam logic [3:0] IDX_COMMON  = 4'h4; // Common request flags.
    localparam logic [3:0] IDX_AUX     = 4'h5; // Auxiliary request flags.
    localparam logic [3:0] IDX_STATUS  = 4'h7; // Primary status register.
    localparam logic [3:0] IDX_RX_MODE = 4'h9; // Receive mode register.

    // ****************************************************************
    // Reset values.
    // ****************************************************************
    localparam logic [7:0] COMMON_RST  = 8'h14; // Common flags after reset.
    localparam logic [7:0] AUX_RST     = 8'h00; // Auxiliary flags after reset.
    localparam logic [7:0] COM_EN_RST  = 8'h80; // Common enables after reset.
    localparam logic [7:0] AUX_EN_RST  = 8'h00; // Auxiliary enables after reset.

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int POLARITY_BIT = 7; // Set or clear select on writes.
    localparam int TX_BIT       = 6; // Transmit done.
    localparam int RX_BIT       = 5; // Receive done.
    localparam int IDLE_BIT     = 4; // Command finished.
    localparam int HI_BIT       = 3; // FIFO high level latched.
    localparam int LO_BIT       = 2; // FIFO low level latched.
    localparam int ERR_BIT      = 1; // Error present.
    localparam int TMR_BIT      = 0; // Countdown reached zero.
    localparam int TEST_BIT     = 4; // Test input edge, auxiliary.
    localparam int CRC_BIT      = 2; // Checksum done, auxiliary.
    localparam int INVERT_BIT   = 7; // Interrupt invert in common enables.
    localparam int STAT_IRQ_BIT = 4; // Global interrupt in status.
    localparam int STAT_HI_BIT  = 1; // Live FIFO high in status.
    localparam int STAT_LO_BIT  = 0; // Live FIFO low in status.
    localparam int SUPPRESS_BIT = 3; // Receive suppress empty in mode.
    localparam logic [7:0] AUX_MASK = 8'h14; // Auxiliary bits with a function.

    // ****************************************************************
    // Commands and bus answers.
    // ****************************************************************
    localparam logic [3:0]  CMD_IDLE    = 4'h0;     // Idle command.
    localparam logic [3:0]  CMD_CRC     = 4'h3;     // Checksum compute command.
    localparam logic [15:0] KNOWN_CMDS  = 16'hd19f; // One bit per known code.
    localparam logic [1:0]  RESP_OKAY   = 2'h0;     // Normal answer.
    localparam logic [1:0]  RESP_SLVERR = 2'h2;     // Unmapped address answer.

    // Write channel states.
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } irqf_wr_type;

    // Event inputs from the sources around the block.
    typedef struct packed {
        logic        tx_done;        // Last transmitted bit sent, pulse.
        logic        rx_end;         // Valid stream end seen, pulse.
        logic        fifo_not_empty; // FIFO holds data bytes, level.
        logic        fifo_high;      // Live FIFO high status, level.
        logic        fifo_low;       // Live FIFO low status, level.
        logic        host_cmd_write; // Host writes the command field, pulse.
        logic        crc_processed;  // All checksum input processed, level.
        logic [3:0]  command;        // Live command field.
        logic [7:0]  error;          // Error status register.
        logic [15:0] timer;          // Timer count register.
    } irqf_events_type;

endpackage

// File: rtl/irqf_flags.sv
// Purpose: Interrupt request flags behind an AXI4-Lite slave.
// Assumes: Event inputs are on CLK except the test input pin.
// Notes:   The interrupt output follows the flags one cycle later.
//
// Overview of operation
// - Common write bit seven selects set or clear
// - Auxiliary register uses the same write scheme
// - Transmit done sets after final bit
// - Receive done sets at valid stream end
// - Suppress option needs FIFO data for receive done
// - Command finished sets when command returns idle
// - Unknown command forced idle and sets flag
// - Host writing idle sets no flag
// - High alert latched until cleared
// - Low alert latched until cleared
// - Error flag sets while any error bit
// - Timer flag sets when count reaches zero
// - Test input edges set its flag
// - Checksum done sets when computation finishes
// - Reset values and positions of both registers
// - Flags never clear themselves
// - Reserved auxiliary bits carry no function
// - Flag reaches interrupt only when enabled
// - Global interrupt bit is any enabled request
// - Invert option inverts the interrupt output
`timescale 1ns/1ps

module irqf_flags #(
    parameter int ADDR_W = 8  // AXI address width.
) (
    input  wire logic                     CLK,
    input  wire logic                     RST_N,
    input  wire logic                     CE,
    input  wire logic [ADDR_W-1:0]        AWADDR,
    input  wire logic                     AWVALID,
    output logic                          AWREADY,
    input  wire logic [31:0]              WDATA,
    input  wire logic [3:0]               WSTRB,
    input  wire logic                     WVALID,
    output logic                          WREADY,
    output logic [1:0]                    BRESP,
    output logic                          BVALID,
    input  wire logic                     BREADY,
    input  wire logic [ADDR_W-1:0]        ARADDR,
    input  wire logic                     ARVALID,
    output logic                          ARREADY,
    output logic [31:0]                   RDATA,
    output logic [1:0]                    RRESP,
    output logic                          RVALID,
    input  wire logic                     RREADY,
    input  wire irqf_pkg::irqf_events_type EVENTS,
    input  wire logic                     TEST_INPUT,
    output logic                          CMD_FORCE_IDLE,
    output logic                          IRQ
);

    // ****************************************************************
    // State of the block, held in one packed struct.
    // ****************************************************************
    typedef struct packed {
        logic [7:0]            common;   // Common flags, bit 7 kept zero.
        logic [7:0]            aux;      // Auxiliary flags.
        logic [7:0]            com_en;   // Common enables and invert.
        logic [7:0]            aux_en;   // Auxiliary enables.
        logic                  suppress; // Receive suppress empty option.
        logic [3:0]            cmd_prev; // Command field one cycle ago.
        logic                  tmr_nz;   // Timer was nonzero last cycle.
        logic                  hi_prev;  // FIFO high status last cycle.
        logic                  lo_prev;  // FIFO low status last cycle.
        logic                  crc_prev; // Checksum completion last cycle.
        logic                  sync1;    // Test input, first stage.
        logic                  sync2;    // Test input, second stage.
        logic                  sync3;    // Test input, edge reference.
        logic                  force_idle; // Unknown command seen.
        logic                  irq;      // Interrupt output level.
        irqf_pkg::irqf_wr_type wr;       // Write channel state.
        logic                  aw_got;   // Write address held.
        logic [ADDR_W-1:0]     awaddr;   // Held write address.
        logic                  w_got;    // Write data held.
        logic [7:0]            wdata;    // Held write byte.
        logic                  wlane;    // Held byte lane zero strobe.
        logic [1:0]            bresp;    // Write answer.
        logic                  rvalid;   // Read answer pending.
        logic [7:0]            rdata;    // Read answer byte.
        logic [1:0]            rresp;    // Read answer code.
    } irqf_state_type;

    localparam irqf_state_type RESET_STATE = '{
        common:   irqf_pkg::COMMON_RST,
        aux:      irqf_pkg::AUX_RST,
        com_en:   irqf_pkg::COM_EN_RST,
        aux_en:   irqf_pkg::AUX_EN_RST,
        suppress: 1'b0,
        cmd_prev: irqf_pkg::CMD_IDLE,
        tmr_nz:   1'b0,
        hi_prev:  1'b0,
        lo_prev:  1'b0,
        crc_prev: 1'b0,
        sync1:    1'b0,
        sync2:    1'b0,
        sync3:    1'b0,
        force_idle: 1'b0,
        irq:      1'b0,
        wr:       irqf_pkg::WR_IDLE,
        aw_got:   1'b0,
        awaddr:   '0,
        w_got:    1'b0,
        wdata:    8'h00,
        wlane:    1'b0,
        bresp:    irqf_pkg::RESP_OKAY,
        rvalid:   1'b0,
        rdata:    8'h00,
        rresp:    irqf_pkg::RESP_OKAY
    };

    irqf_state_type    s;        // Registered state.
    irqf_state_type    next_s;   // Next state.
    logic              aw_take;  // Write address taken this cycle.
    logic              w_take;   // Write data taken this cycle.
    logic              ar_take;  // Read address taken this cycle.
    logic [ADDR_W-1:0] wr_addr;  // Write address in use.
    logic [7:0]        wr_byte;  // Write byte in use.
    logic              wr_lane;  // Byte lane zero strobe in use.
    logic [7:0]        com_set;  // Common bits set by software.
    logic [7:0]        com_clr;  // Common bits cleared by software.
    logic [7:0]        aux_set;  // Auxiliary bits set by software.
    logic [7:0]        aux_clr;  // Auxiliary bits cleared by software.
    logic [7:0]        com_ev;   // Common bits set by hardware.
    logic [7:0]        aux_ev;   // Auxiliary bits set by hardware.
    logic              any_req;  // Some enabled request is pending.
    logic [7:0]        status;   // Status register contents.

    // ****************************************************************
    // Address decoding.
    // ****************************************************************

    // Register index of an aligned, mapped address.
    // Fifteen marks an address with no register.
    function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] addr);
        logic [3:0] idx;
        idx = addr[5:2];
        if (addr[1:0] != 2'h0 || (addr >> 6) != '0) begin
            return 4'hf;
        end
        case (idx)
            irqf_pkg::IDX_COM_EN, irqf_pkg::IDX_AUX_EN,
            irqf_pkg::IDX_COMMON, irqf_pkg::IDX_AUX,
            irqf_pkg::IDX_STATUS, irqf_pkg::IDX_RX_MODE: begin
                return idx;
            end
            default: begin
                return 4'hf;
            end
        endcase
    endfunction

    // ****************************************************************
    // Bus handshakes.
    // ****************************************************************

    // Readies are gated by the clock enable so that no item is taken
    // while the state is frozen.
    assign AWREADY = CE && !s.aw_got && s.wr == irqf_pkg::WR_IDLE;
    assign WREADY  = CE && !s.w_got && s.wr == irqf_pkg::WR_IDLE;
    assign ARREADY = CE && !s.rvalid;
    assign BVALID  = s.wr == irqf_pkg::WR_RESP;
    assign BRESP   = s.bresp;
    assign RVALID  = s.rvalid;
    assign RRESP   = s.rresp;
    assign RDATA   = {24'h000000, s.rdata};
    assign CMD_FORCE_IDLE = s.force_idle;
    assign IRQ     = s.irq;

    assign aw_take = AWVALID && AWREADY;
    assign w_take  = WVALID && WREADY;
    assign ar_take = ARVALID && ARREADY;
    assign wr_addr = s.aw_got ? s.awaddr : AWADDR;
    assign wr_byte = s.w_got ? s.wdata : WDATA[7:0];
    assign wr_lane = s.w_got ? s.wlane : WSTRB[0];

    // ****************************************************************
    // Next state.
    // ****************************************************************

    // Software masks, hardware events, flag update, bus channels.
    always_comb begin
        next_s  = s;
        com_set = 8'h00;
        com_clr = 8'h00;
        aux_set = 8'h00;
        aux_clr = 8'h00;

        // Address and data may arrive in either order.
        if (aw_take) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = AWADDR;
        end
        if (w_take) begin
            next_s.w_got = 1'b1;
            next_s.wdata = WDATA[7:0];
            next_s.wlane = WSTRB[0];
        end

        case (s.wr)
            irqf_pkg::WR_IDLE: begin
                // Both halves present: the write takes effect.
                if ((s.aw_got || aw_take) && (s.w_got || w_take)) begin
                    next_s.aw_got = 1'b0;
                    next_s.w_got  = 1'b0;
                    next_s.wr     = irqf_pkg::WR_RESP;
                    next_s.bresp  = irqf_pkg::RESP_OKAY;
                    if (reg_index(wr_addr) == 4'hf) begin
                        next_s.bresp = irqf_pkg::RESP_SLVERR;
                    end else if (wr_lane) begin
                        case (reg_index(wr_addr))
                            irqf_pkg::IDX_COMMON: begin
                                // Bit seven picks set or clear of marked bits.
                                if (wr_byte[irqf_pkg::POLARITY_BIT]) begin
                                    com_set = {1'b0, wr_byte[6:0]};
                                end else begin
                                    com_clr = {1'b0, wr_byte[6:0]};
                                end
                            end
                            irqf_pkg::IDX_AUX: begin
                                // Only the two functional bits are affected.
                                if (wr_byte[irqf_pkg::POLARITY_BIT]) begin
                                    aux_set = wr_byte & irqf_pkg::AUX_MASK;
                                end else begin
                                    aux_clr = wr_byte & irqf_pkg::AUX_MASK;
                                end
                            end
                            irqf_pkg::IDX_COM_EN: begin
                                next_s.com_en = wr_byte;
                            end
                            irqf_pkg::IDX_AUX_EN: begin
                                next_s.aux_en = wr_byte;
                            end
                            irqf_pkg::IDX_RX_MODE: begin
                                next_s.suppress = wr_byte[irqf_pkg::SUPPRESS_BIT];
                            end
                            default: begin
                                // Status is read only; writes are ignored.
                            end
                        endcase
                    end
                end
            end
            irqf_pkg::WR_RESP: begin
                // The answer stands until the master takes it.
                if (BREADY) begin
                    next_s.wr = irqf_pkg::WR_IDLE;
                end
            end
            default: begin
                next_s.wr = irqf_pkg::WR_IDLE;
            end
        endcase

        // Hardware events for the common register.
        com_ev = 8'h00;
        com_ev[irqf_pkg::TX_BIT] = EVENTS.tx_done;
        // An empty FIFO hides the end of reception when suppression is on.
        com_ev[irqf_pkg::RX_BIT] = EVENTS.rx_end &&
                                   (!s.suppress || EVENTS.fifo_not_empty);
        // A command that ends by itself sets the flag, a host idle does not.
        com_ev[irqf_pkg::IDLE_BIT] =
            (s.cmd_prev != irqf_pkg::CMD_IDLE &&
             EVENTS.command == irqf_pkg::CMD_IDLE &&
             !EVENTS.host_cmd_write) ||
            !irqf_pkg::KNOWN_CMDS[EVENTS.command];
        com_ev[irqf_pkg::HI_BIT]  = EVENTS.fifo_high && !s.hi_prev;
        com_ev[irqf_pkg::LO_BIT]  = EVENTS.fifo_low && !s.lo_prev;
        com_ev[irqf_pkg::ERR_BIT] = |EVENTS.error;
        com_ev[irqf_pkg::TMR_BIT] = s.tmr_nz && EVENTS.timer == 16'h0000;

        // Hardware events for the auxiliary register.
        aux_ev = 8'h00;
        aux_ev[irqf_pkg::TEST_BIT] = s.sync2 ^ s.sync3;
        aux_ev[irqf_pkg::CRC_BIT]  = (EVENTS.command == irqf_pkg::CMD_CRC &&
                                      EVENTS.crc_processed) && !s.crc_prev;

        // Flags change only by event or software; a set wins over a clear.
        next_s.common = ((s.common & ~com_clr) | com_set | com_ev) & 8'h7f;
        next_s.aux    = ((s.aux & ~aux_clr) | aux_set | aux_ev)
                        & irqf_pkg::AUX_MASK;

        // Event history for edge detection.
        next_s.cmd_prev   = EVENTS.command;
        next_s.tmr_nz     = EVENTS.timer != 16'h0000;
        next_s.hi_prev    = EVENTS.fifo_high;
        next_s.lo_prev    = EVENTS.fifo_low;
        next_s.crc_prev   = EVENTS.command == irqf_pkg::CMD_CRC && EVENTS.crc_processed;
        next_s.force_idle = !irqf_pkg::KNOWN_CMDS[EVENTS.command];

        // The pin passes two stages before the edge detector reads it.
        next_s.sync1 = TEST_INPUT;
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;

        // Interrupt output, registered so the pin never glitches.
        next_s.irq = any_req ^ s.com_en[irqf_pkg::INVERT_BIT];

        // Read answer latched at the address handshake.
        if (s.rvalid && RREADY) begin
            next_s.rvalid = 1'b0;
        end
        if (ar_take) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = irqf_pkg::RESP_OKAY;
            next_s.rdata  = 8'h00;
            case (reg_index(ARADDR))
                irqf_pkg::IDX_COMMON: begin
                    next_s.rdata = s.common;
                end
                irqf_pkg::IDX_AUX: begin
                    next_s.rdata = s.aux;
                end
                irqf_pkg::IDX_COM_EN: begin
                    next_s.rdata = s.com_en;
                end
                irqf_pkg::IDX_AUX_EN: begin
                    next_s.rdata = s.aux_en;
                end
                irqf_pkg::IDX_STATUS: begin
                    next_s.rdata = status;
                end
                irqf_pkg::IDX_RX_MODE: begin
                    next_s.rdata[irqf_pkg::SUPPRESS_BIT] = s.suppress;
                end
                default: begin
                    next_s.rresp = irqf_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // ****************************************************************
    // Interrupt gating and status.
    // ****************************************************************

    // Each flag counts only while its enable bit is one.
    assign any_req = |(s.common[6:0] & s.com_en[6:0]) ||
                     |(s.aux & s.aux_en & irqf_pkg::AUX_MASK);

    // Status: global request and live FIFO levels.
    always_comb begin
        status = 8'h00;
        status[irqf_pkg::STAT_IRQ_BIT] = any_req;
        status[irqf_pkg::STAT_HI_BIT]  = EVENTS.fifo_high;
        status[irqf_pkg::STAT_LO_BIT]  = EVENTS.fifo_low;
    end

    // ****************************************************************
    // State register.
    // ****************************************************************

    // Synchronous reset to constants; a low clock enable holds all state.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s <= RESET_STATE;
        end else if (CE) begin
            s <= next_s;
        end
    end

endmodule

// File: tb/irqf_flags_asserts.sv
// Purpose: Port checks of the flag block.
// Assumes: One clock, synchronous low reset.
// Notes:   Sees the top module's ports only.
`timescale 1ns/1ps
module irqf_flags_asserts (
    input wire logic                      CLK,
    input wire logic                      RST_N,
    input wire logic                      CE,
    input wire logic                      AWVALID,
    input wire logic                      AWREADY,
    input wire logic                      WVALID,
    input wire logic                      WREADY,
    input wire logic [1:0]                BRESP,
    input wire logic                      BVALID,
    input wire logic                      BREADY,
    input wire logic                      ARVALID,
    input wire logic                      ARREADY,
    input wire logic [31:0]               RDATA,
    input wire logic                      RVALID,
    input wire logic                      RREADY,
    input wire irqf_pkg::irqf_events_type EVENTS,
    input wire logic                      CMD_FORCE_IDLE,
    input wire logic                      IRQ
);
    // ****************************************************************
    // Bus and pin checks.
    // ****************************************************************
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Write and read handshakes.
    sequence s_wr; AWVALID && AWREADY && WVALID && WREADY; endsequence
    sequence s_rd; ARVALID && ARREADY; endsequence
    property p_wr_ans; s_wr |=> BVALID; endproperty
    property p_rd_ans; s_rd |=> RVALID && (RDATA[31:8] == 24'h0); endproperty
    property p_b_hold; BVALID && !BREADY |=> BVALID && $stable(BRESP); endproperty
    property p_r_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
    property p_b_block; BVALID |-> !AWREADY && !WREADY; endproperty
    property p_unk; CE && !irqf_pkg::KNOWN_CMDS[EVENTS.command] |=> CMD_FORCE_IDLE; endproperty
    property p_known; CE && irqf_pkg::KNOWN_CMDS[EVENTS.command] |=> !CMD_FORCE_IDLE; endproperty
    // Reset must not disable its own checks.
    property p_rst; disable iff (1'b0) !RST_N |=> !BVALID && !RVALID; endproperty
    property p_irq_rst; disable iff (1'b0) !RST_N ##1 (RST_N && CE) |=> IRQ; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    a_b_block: assert property (p_b_block) else $error("write taken early");
    a_unk: assert property (p_unk) else $error("unknown code not forced");
    a_known: assert property (p_known) else $error("known code forced");
    a_rst: assert property (p_rst) else $error("answer after reset");
    a_irq_rst: assert property (p_irq_rst) else $error("pin level after reset");
endmodule
bind irqf_flags irqf_flags_asserts u_chk (.CLK(CLK), .RST_N(RST_N), .CE(CE),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
    .EVENTS(EVENTS), .CMD_FORCE_IDLE(CMD_FORCE_IDLE), .IRQ(IRQ));

// File: tb/testbench.sv
// Purpose: Checks the interrupt request flag block.
// Assumes: Outputs sampled at falling edges.
// Notes:   Rows first, then events, pin and reset.
`timescale 1ns/1ps
module testbench;
    typedef struct packed {logic [7:0] wa, wd, ra, ex; logic [1:0] rs;} irqf_row_type;
    logic CLK, RST_N, CE, AWVALID, WVALID, BREADY, ARVALID, RREADY, TEST_INPUT;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CMD_FORCE_IDLE, IRQ;
    logic [7:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, d;
    logic [1:0] BRESP, RRESP, bresp_seen;
    irqf_pkg::irqf_events_type EVENTS;
    int err_total = 0, samples_checked = 0;
    // Flag writes, each read back.
    irqf_row_type rows [9] = '{'{8'h10,8'h14,8'h10,8'h00,2'h0}, '{8'h10,8'hff,8'h10,8'h7f,2'h0},
        '{8'h10,8'h41,8'h10,8'h3e,2'h0}, '{8'h10,8'h00,8'h10,8'h3e,2'h0},
        '{8'h10,8'h3e,8'h10,8'h00,2'h0}, '{8'h14,8'hff,8'h14,8'h14,2'h0},
        '{8'h14,8'h04,8'h14,8'h10,2'h0}, '{8'h14,8'h10,8'h14,8'h00,2'h0},
        '{8'h40,8'hff,8'h10,8'h00,irqf_pkg::RESP_SLVERR}};
    irqf_flags u_dut (.CLK(CLK), .RST_N(RST_N), .CE(CE), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .EVENTS(EVENTS), .TEST_INPUT(TEST_INPUT), .CMD_FORCE_IDLE(CMD_FORCE_IDLE), .IRQ(IRQ));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Readies are sampled settled, at the falling edge.
    task automatic wr(input logic [7:0] a, v);
        logic ta, tw, tb;
        AWADDR <= a; WDATA <= {24'h0, v}; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
        do begin
            @(negedge CLK); ta = AWVALID && AWREADY; tw = WVALID && WREADY; tb = BVALID;
            bresp_seen = BRESP;
            @(posedge CLK); if (ta) AWVALID <= 1'b0; if (tw) WVALID <= 1'b0;
        end while (!tb);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic ta, tr;
        ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
        do begin
            @(negedge CLK); ta = ARVALID && ARREADY; tr = RVALID; q = RDATA;
            @(posedge CLK); if (ta) ARVALID <= 1'b0;
        end while (!tr);
    endtask
    // Two event cycles, then read and clear flags.
    task automatic ev(input irqf_pkg::irqf_events_type a, b, input logic [7:0] ec, ea);
        EVENTS <= a; @(posedge CLK); EVENTS <= b; @(posedge CLK); EVENTS <= '0;
        repeat (6) @(posedge CLK);
        rd(8'h10, d); chk("common flags", d, {24'h0, ec});
        rd(8'h14, d); chk("aux flags", d, {24'h0, ea});
        wr(8'h10, 8'h7f); wr(8'h14, 8'h14);
    endtask
    task automatic irq_chk(input logic e);
        repeat (3) @(negedge CLK);
        chk("irq pin", {31'h0, IRQ}, {31'h0, e});
        @(posedge CLK);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge CLK);
        err_total++;
        complete_run();
    end
    initial begin
        {RST_N, CE, AWVALID, WVALID, BREADY, ARVALID, RREADY, TEST_INPUT} = '0;
        {AWADDR, ARADDR, WDATA, EVENTS} = '0;
        repeat (16) @(posedge CLK);
        {RST_N, CE} <= 2'b11;
        @(posedge CLK);
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd); chk("write answer", bresp_seen, rows[i].rs);
            rd(rows[i].ra, d); chk("flag rows", d, {24'h0, rows[i].ex});
        end
        $display("test flag rows done");
        ev('{tx_done:1'b1, default:'0}, '0, 8'h40, 8'h00);
        ev('{rx_end:1'b1, default:'0}, '0, 8'h20, 8'h00);
        ev('{command:4'h1, default:'0}, '0, 8'h10, 8'h00);
        ev('{command:4'h1, default:'0}, '{host_cmd_write:1'b1, default:'0}, 8'h00, 8'h00);
        ev('{command:4'h5, default:'0}, '0, 8'h10, 8'h00);
        ev('{fifo_high:1'b1, default:'0}, '0, 8'h08, 8'h00);
        ev('{fifo_low:1'b1, default:'0}, '0, 8'h04, 8'h00);
        ev('{error:8'h10, default:'0}, '0, 8'h02, 8'h00);
        ev('{timer:16'h5, default:'0}, '0, 8'h01, 8'h00);
        ev('{command:4'h3, crc_processed:1'b1, default:'0}, '0, 8'h10, 8'h04);
        wr(8'h24, 8'h08);
        ev('{rx_end:1'b1, default:'0}, '0, 8'h00, 8'h00);
        ev('{rx_end:1'b1, fifo_not_empty:1'b1, default:'0}, '0, 8'h20, 8'h00);
        TEST_INPUT <= 1'b1; ev('0, '0, 8'h00, 8'h10);
        TEST_INPUT <= 1'b0; ev('0, '0, 8'h00, 8'h10);
        CE <= 1'b0; EVENTS.tx_done <= 1'b1;
        @(posedge CLK); CE <= 1'b1; EVENTS <= '0;
        rd(8'h10, d); chk("frozen", d, 32'h0);
        $display("test events done");
        wr(8'h08, 8'h40); wr(8'h10, 8'hc0); irq_chk(1'b1);
        rd(8'h1c, d); chk("global status", d, 32'h10);
        wr(8'h08, 8'h00); irq_chk(1'b0);
        wr(8'h08, 8'h80); irq_chk(1'b1);
        $display("test pin done");
        RST_N <= 1'b0; repeat (2) @(posedge CLK); RST_N <= 1'b1; @(posedge CLK);
        rd(8'h10, d); chk("common reset", d, 32'h14);
        rd(8'h14, d); chk("aux reset", d, 32'h0);
        $display("test reset done");
        complete_run();
    end
endmodule
